// >>> drive_cap_pkg.sv
// Purpose: Shared constants for the speed cap and outage hold block
// Assumes: 25 MHz system clock, 32-bit register port
// Notes:   Offsets are byte addresses on the plain register port
// Functional notes
// - Approach flag when deviation magnitude within near width
// - Clamp speed to limit during torque control
// - Speed-limited flag high while clamping is active
// - Source select picks max or overspeed speed
// - Cap from torque or force register, 0..10000
// - Cap above source speed falls back to source
// - Keep power through outage up to ride time
// - Restore motor power when main supply recovers
// - Drop ready when outage exceeds ride time
// - Control supply loss acts as normal power-off
// - Undervoltage during outage abandons the hold
package drive_cap_pkg;
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] TORQUE_CAP_OFS = 8'h04;
  localparam logic [7:0] FORCE_CAP_OFS = 8'h08;
  localparam logic [7:0] MAX_SPEED_OFS = 8'h0c;
  localparam logic [7:0] OVERSPEED_OFS = 8'h10;
  localparam logic [7:0] RIDE_TIME_OFS = 8'h14;
  localparam logic [7:0] NEAR_OFS      = 8'h18;
  localparam logic [7:0] COMPL_OFS     = 8'h1c;
  localparam logic [7:0] STATUS_OFS    = 8'h20;
  localparam logic [7:0] EV_STATUS_OFS = 8'h24;
  localparam logic [7:0] EV_CLEAR_OFS  = 8'h28;
  localparam logic [7:0] EV_ENABLE_OFS = 8'h2c;
  localparam logic [7:0] LIMIT_OFS     = 8'h30;

  localparam int CTRL_TORQUE_BIT = 0;
  localparam int CTRL_LINEAR_BIT = 1;
  localparam int CTRL_SRC_BIT    = 2;
  localparam int CTRL_W          = 3;

  localparam int ST_LIMITED  = 0;
  localparam int ST_APPROACH = 1;
  localparam int ST_POWER    = 2;
  localparam int ST_READY    = 3;
  localparam int ST_OUTAGE   = 4;

  localparam int EV_LIMIT   = 0;
  localparam int EV_OUTAGE  = 1;
  localparam int EV_CUT     = 2;
  localparam int EV_RECOVER = 3;
  localparam int EV_W       = 4;

  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [15:0] CAP_RST       = 16'h2710;
  localparam logic [15:0] CAP_MAX       = 16'h2710;
  localparam logic [15:0] MAX_SPEED_RST = 16'h2710;
  localparam logic [15:0] OVERSPEED_RST = 16'h2710;
  localparam logic [15:0] RIDE_RST      = 16'h0014;
  localparam logic [15:0] RIDE_MIN      = 16'h0014;
  localparam logic [15:0] RIDE_MAX      = 16'hc350;
  localparam logic [30:0] NEAR_RST      = 31'h4000_0000;
  localparam logic [30:0] NEAR_MIN      = 31'h0000_0001;
  localparam logic [30:0] NEAR_MAX      = 31'h4000_0000;
  localparam logic [30:0] COMPL_RST     = 31'h0000_0007;
  localparam logic [EV_W-1:0] EV_EN_RST = 4'h0;

  localparam int CLK_HZ    = 25_000_000;
  localparam int MS_TIME   = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;

  typedef enum logic [1:0] {PWR_OFF, PWR_RUN, PWR_HOLD, PWR_CUT} pwr_state_type;
endpackage : drive_cap_pkg

// >>> signed_mag.sv
// Purpose: Magnitude of a two's complement value
// Assumes: Most negative input maps to its unsigned magnitude
// Notes:   Used for speed demand and position deviation
`timescale 1ns/1ps
module signed_mag #(
  parameter int W = 16
) (
  input  logic signed [W-1:0] val, // Signed input
  output logic        [W-1:0] mag  // Absolute value
);
  assign mag = val[W-1] ? W'(-val) : W'(val);
endmodule : signed_mag

// >>> drive_cap_outage.sv
// Purpose: Speed cap in torque mode, outage ride-through, near flag
// Assumes: Inputs synchronous to clk_sys, supply flags debounced
// Notes:   Registers on a plain strobe port, read data one cycle later
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module drive_cap_outage #(
  parameter int MS_CYCLES = drive_cap_pkg::MS_CYCLES
) (
  input  logic               clk_sys,            // 25 MHz clock
  input  logic               sys_rst,            // Sync reset, high
  input  logic [7:0]         reg_addr,           // Byte address
  input  logic [31:0]        reg_wdata,          // Write data
  input  logic               reg_wr,             // Write strobe
  input  logic               reg_rd,             // Read strobe
  output logic [31:0]        reg_rdata,          // Read data, next cycle
  input  logic signed [16:0] speed_demand,       // Speed before cap
  output logic signed [16:0] speed_cmd,          // Speed after cap
  output logic               speed_limited_flag, // Clamping active
  input  logic signed [31:0] position_deviation, // Deviation counter
  output logic               approach_flag,      // Near positioning
  input  logic               main_supply_ok,     // Main circuit present
  input  logic               control_supply_ok,  // Control logic alive
  input  logic               undervoltage_alarm, // Supply undervoltage
  input  logic               servo_on_req,       // Host servo-on
  output logic               motor_power_on,     // Power stage enable
  output logic               drive_ready,        // Servo ready
  output logic               irq                 // Level interrupt
);
  logic [drive_cap_pkg::CTRL_W-1:0] ctrl_q;
  logic [15:0]                      torque_cap_q;
  logic [15:0]                      force_cap_q;
  logic [15:0]                      max_speed_q;
  logic [15:0]                      overspeed_q;
  logic [15:0]                      ride_q;
  logic [30:0]                      near_q;
  logic [30:0]                      compl_q;
  logic [drive_cap_pkg::EV_W-1:0]   ev_q;
  logic [drive_cap_pkg::EV_W-1:0]   ev_en_q;
  logic [31:0]                      rdata_q;
  logic signed [16:0]               cmd_q;
  logic                             limited_q;
  logic                             approach_q;
  logic                             power_q;
  logic                             ready_q;
  logic [15:0]                      pre_q;
  logic [15:0]                      ms_q;
  drive_cap_pkg::pwr_state_type     state_q;
  drive_cap_pkg::pwr_state_type     state_d;

  // Address decode
  wire wr_ctrl  = reg_wr && reg_addr == drive_cap_pkg::CTRL_OFS;
  wire wr_tcap  = reg_wr && reg_addr == drive_cap_pkg::TORQUE_CAP_OFS;
  wire wr_fcap  = reg_wr && reg_addr == drive_cap_pkg::FORCE_CAP_OFS;
  wire wr_max   = reg_wr && reg_addr == drive_cap_pkg::MAX_SPEED_OFS;
  wire wr_ovs   = reg_wr && reg_addr == drive_cap_pkg::OVERSPEED_OFS;
  wire wr_ride  = reg_wr && reg_addr == drive_cap_pkg::RIDE_TIME_OFS;
  wire wr_near  = reg_wr && reg_addr == drive_cap_pkg::NEAR_OFS;
  wire wr_compl = reg_wr && reg_addr == drive_cap_pkg::COMPL_OFS;
  wire wr_clr   = reg_wr && reg_addr == drive_cap_pkg::EV_CLEAR_OFS;
  wire wr_en    = reg_wr && reg_addr == drive_cap_pkg::EV_ENABLE_OFS;

  // Out-of-range writes saturate so the logic never sees them
  wire [15:0] cap_w = reg_wdata[31:16] != 16'h0 || reg_wdata[15:0] > drive_cap_pkg::CAP_MAX
                      ? drive_cap_pkg::CAP_MAX : reg_wdata[15:0];
  wire [15:0] ride_w = reg_wdata[31:16] != 16'h0 || reg_wdata[15:0] > drive_cap_pkg::RIDE_MAX
                       ? drive_cap_pkg::RIDE_MAX
                       : reg_wdata[15:0] < drive_cap_pkg::RIDE_MIN
                       ? drive_cap_pkg::RIDE_MIN : reg_wdata[15:0];
  wire [30:0] near_w = reg_wdata[31] || reg_wdata[30:0] > drive_cap_pkg::NEAR_MAX
                       ? drive_cap_pkg::NEAR_MAX
                       : reg_wdata[30:0] < drive_cap_pkg::NEAR_MIN
                       ? drive_cap_pkg::NEAR_MIN : reg_wdata[30:0];
  // Completion width may be zero, so only the top end saturates
  wire [30:0] compl_w = reg_wdata[31] || reg_wdata[30:0] > drive_cap_pkg::NEAR_MAX
                        ? drive_cap_pkg::NEAR_MAX : reg_wdata[30:0];

  // Effective limit
  wire        torque_mode = ctrl_q[drive_cap_pkg::CTRL_TORQUE_BIT];
  wire [15:0] cfg_cap = ctrl_q[drive_cap_pkg::CTRL_LINEAR_BIT] ? force_cap_q : torque_cap_q;
  wire [15:0] src_speed = ctrl_q[drive_cap_pkg::CTRL_SRC_BIT] ? overspeed_q : max_speed_q;
  wire [15:0] eff_limit = cfg_cap > src_speed ? src_speed : cfg_cap;

  wire [16:0] demand_mag;
  signed_mag #(.W(17)) u_demand_mag (
    .val (speed_demand),
    .mag (demand_mag)
  );
  wire               exceed = torque_mode && demand_mag > {1'b0, eff_limit};
  wire signed [16:0] lim_s  = {1'b0, eff_limit};
  wire signed [16:0] cmd_d  = !exceed ? speed_demand
                              : speed_demand[16] ? -lim_s : lim_s;

  wire [31:0] dev_mag;
  signed_mag #(.W(32)) u_dev_mag (
    .val (position_deviation),
    .mag (dev_mag)
  );
  wire approach_d = dev_mag <= {1'b0, near_q};

  // Outage timing
  wire ms_tick    = pre_q == 16'(MS_CYCLES - 1);
  wire ride_spent = ms_tick && ms_q >= ride_q;
  wire in_outage  = state_q == drive_cap_pkg::PWR_HOLD;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      drive_cap_pkg::PWR_OFF:
        if (control_supply_ok && main_supply_ok)
          state_d = drive_cap_pkg::PWR_RUN;
      drive_cap_pkg::PWR_RUN:
        if (!control_supply_ok)
          state_d = drive_cap_pkg::PWR_OFF;
        else if (!main_supply_ok)
          state_d = drive_cap_pkg::PWR_HOLD;
      drive_cap_pkg::PWR_HOLD:
        if (!control_supply_ok)
          state_d = drive_cap_pkg::PWR_OFF;
        else if (main_supply_ok)
          state_d = drive_cap_pkg::PWR_RUN;
        else if (undervoltage_alarm || ride_spent)
          state_d = drive_cap_pkg::PWR_CUT;
      drive_cap_pkg::PWR_CUT:
        if (!control_supply_ok)
          state_d = drive_cap_pkg::PWR_OFF;
        else if (main_supply_ok)
          state_d = drive_cap_pkg::PWR_RUN;
    endcase
  end

  wire alive_d = state_d == drive_cap_pkg::PWR_RUN || state_d == drive_cap_pkg::PWR_HOLD;

  // Events, set beats clear in the same cycle
  wire [drive_cap_pkg::EV_W-1:0] ev_set = {
    state_d == drive_cap_pkg::PWR_RUN && (in_outage || state_q == drive_cap_pkg::PWR_CUT),
    in_outage && state_d == drive_cap_pkg::PWR_CUT,
    state_q == drive_cap_pkg::PWR_RUN && state_d == drive_cap_pkg::PWR_HOLD,
    exceed && !limited_q
  };
  wire [drive_cap_pkg::EV_W-1:0] ev_clr = wr_clr ? reg_wdata[drive_cap_pkg::EV_W-1:0] : '0;
  wire [drive_cap_pkg::EV_W-1:0] ev_d   = ev_set | (ev_q & ~ev_clr);

  wire [31:0] status_w = {27'h0, in_outage, ready_q, power_q, approach_q, limited_q};
  wire [31:0] rd_mux =
    reg_addr == drive_cap_pkg::CTRL_OFS       ? {29'h0, ctrl_q} :
    reg_addr == drive_cap_pkg::TORQUE_CAP_OFS ? {16'h0, torque_cap_q} :
    reg_addr == drive_cap_pkg::FORCE_CAP_OFS  ? {16'h0, force_cap_q} :
    reg_addr == drive_cap_pkg::MAX_SPEED_OFS  ? {16'h0, max_speed_q} :
    reg_addr == drive_cap_pkg::OVERSPEED_OFS  ? {16'h0, overspeed_q} :
    reg_addr == drive_cap_pkg::RIDE_TIME_OFS  ? {16'h0, ride_q} :
    reg_addr == drive_cap_pkg::NEAR_OFS       ? {1'b0, near_q} :
    reg_addr == drive_cap_pkg::COMPL_OFS      ? {1'b0, compl_q} :
    reg_addr == drive_cap_pkg::STATUS_OFS     ? status_w :
    reg_addr == drive_cap_pkg::EV_STATUS_OFS  ? {28'h0, ev_q} :
    reg_addr == drive_cap_pkg::EV_ENABLE_OFS  ? {28'h0, ev_en_q} :
    reg_addr == drive_cap_pkg::LIMIT_OFS      ? {16'h0, eff_limit} : 32'h0;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl_q       <= drive_cap_pkg::CTRL_RST;
      torque_cap_q <= drive_cap_pkg::CAP_RST;
      force_cap_q  <= drive_cap_pkg::CAP_RST;
      max_speed_q  <= drive_cap_pkg::MAX_SPEED_RST;
      overspeed_q  <= drive_cap_pkg::OVERSPEED_RST;
      ride_q       <= drive_cap_pkg::RIDE_RST;
      near_q       <= drive_cap_pkg::NEAR_RST;
      compl_q      <= drive_cap_pkg::COMPL_RST;
      ev_en_q      <= drive_cap_pkg::EV_EN_RST;
    end
    else
    begin
      if (wr_ctrl)  ctrl_q       <= reg_wdata[drive_cap_pkg::CTRL_W-1:0];
      if (wr_tcap)  torque_cap_q <= cap_w;
      if (wr_fcap)  force_cap_q  <= cap_w;
      if (wr_max)   max_speed_q  <= reg_wdata[15:0];
      if (wr_ovs)   overspeed_q  <= reg_wdata[15:0];
      if (wr_ride)  ride_q       <= ride_w;
      if (wr_near)  near_q       <= near_w;
      if (wr_compl) compl_q      <= compl_w;
      if (wr_en)    ev_en_q      <= reg_wdata[drive_cap_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdata_q    <= 32'h0;
      ev_q       <= '0;
      cmd_q      <= 17'h0;
      limited_q  <= 1'b0;
      approach_q <= 1'b0;
    end
    else
    begin
      rdata_q    <= reg_rd ? rd_mux : 32'h0;
      ev_q       <= ev_d;
      cmd_q      <= cmd_d;
      limited_q  <= exceed;
      approach_q <= approach_d;
    end
  end

  // Prescaler only runs during an outage so each hold starts on a whole ms
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= drive_cap_pkg::PWR_OFF;
      pre_q   <= 16'h0;
      ms_q    <= 16'h0;
      power_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // Supply return clears the prescaler too, so a later hold starts fresh
      pre_q   <= !in_outage || main_supply_ok || ms_tick ? 16'h0 : pre_q + 16'h1;
      ms_q    <= !in_outage || main_supply_ok ? 16'h0
                 : ms_tick ? ms_q + 16'h1 : ms_q;
      power_q <= servo_on_req && alive_d;
      ready_q <= alive_d;
    end
  end

  assign reg_rdata          = rdata_q;
  assign speed_cmd          = cmd_q;
  assign speed_limited_flag = limited_q;
  assign approach_flag      = approach_q;
  assign motor_power_on     = power_q;
  assign drive_ready        = ready_q;
  assign irq                = |(ev_q & ev_en_q);

  chk_near_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> approach_flag == ($past(dev_mag) <= {1'b0, $past(near_q)}))
    else $error("approach flag disagrees with deviation");

  chk_cmd_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    torque_mode |=> (speed_cmd[16] ? 17'(-speed_cmd) : speed_cmd) <= {1'b0, $past(eff_limit)})
    else $error("speed command above limit in torque mode");

  chk_flag_clamp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    speed_limited_flag |-> speed_cmd == (speed_cmd[16] ? -$past(lim_s) : $past(lim_s))
                           && $past(speed_demand) != speed_cmd)
    else $error("limited flag without clamped command");

  chk_src_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    eff_limit <= (ctrl_q[drive_cap_pkg::CTRL_SRC_BIT] ? overspeed_q : max_speed_q)
    && eff_limit <= cfg_cap)
    else $error("limit exceeds selected source or cap");

  chk_cap_pick: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ctrl_q[drive_cap_pkg::CTRL_LINEAR_BIT] && torque_cap_q <= src_speed |-> eff_limit == torque_cap_q)
    else $error("torque cap not used for rotary motor");

  chk_cap_fallback: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_cap > src_speed |-> eff_limit == src_speed)
    else $error("cap above source speed not replaced");

  chk_hold_power: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_outage && control_supply_ok && !undervoltage_alarm && ms_q < ride_q
    |=> state_q != drive_cap_pkg::PWR_CUT)
    else $error("power cut before ride time");

  chk_recover: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_q == drive_cap_pkg::PWR_CUT && main_supply_ok && control_supply_ok
    |=> state_q == drive_cap_pkg::PWR_RUN ##1 drive_ready)
    else $error("no recovery after supply returned");

  chk_ready_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(drive_ready) |-> $past(state_d) inside {drive_cap_pkg::PWR_CUT, drive_cap_pkg::PWR_OFF})
    else $error("ready dropped without outage end");

  chk_ctrl_loss: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !control_supply_ok |=> !motor_power_on && !drive_ready)
    else $error("power kept after control supply loss");

  chk_uv_abandon: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_outage && control_supply_ok && !main_supply_ok && undervoltage_alarm
    |=> state_q == drive_cap_pkg::PWR_CUT ##1 !motor_power_on)
    else $error("hold kept under undervoltage");

  chk_ms_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    main_supply_ok |=> ms_q == 16'h0 && pre_q == 16'h0)
    else $error("outage counter not cleared");

  chk_ready_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_outage |-> drive_ready)
    else $error("ready dropped during outage hold");

  chk_cut_expiry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    in_outage && control_supply_ok && !main_supply_ok && ms_tick && ms_q >= ride_q
    |=> state_q == drive_cap_pkg::PWR_CUT && !motor_power_on && !drive_ready)
    else $error("power kept after ride time expired");

  chk_servo_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !servo_on_req |=> !motor_power_on)
    else $error("power on without servo request");
endmodule : drive_cap_outage

// >>> supply_link_model.sv
// Purpose: Main and control supplies as the drive sees them
// Assumes: Bench drives the requests off the clock edge
// Notes:   Undervoltage only appears while main is lost under load
`timescale 1ns/1ps
module supply_link_model (
  input  wire logic clk_sys,                   // Bench clock
  input  wire logic cut_main,                  // Open the main breaker
  input  wire logic cut_control,               // Drop the control supply
  input  wire logic heavy_load,                // Large load during outage
  output logic      main_supply_ok     = 1'b1, // Main circuit present
  output logic      control_supply_ok  = 1'b1, // Control logic alive
  output logic      undervoltage_alarm = 1'b0  // Bus sagged under load
);
  // Registered like a real debounced supply monitor
  always_ff @(posedge clk_sys)
  begin
    main_supply_ok     <= !cut_main;
    control_supply_ok  <= !cut_control;
    undervoltage_alarm <= cut_main && heavy_load;
  end
endmodule : supply_link_model

// >>> tb.sv
// Purpose: Self-checking bench for the speed cap and outage hold block
// Assumes: Millisecond prescale shortened to 4 cycles
// Notes:   Outage checks use margins around the hold expiry
`timescale 1ns/1ps
module tb;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata;
  logic signed [16:0] speed_demand = 17'h00000;
  logic signed [16:0] speed_cmd;
  logic signed [31:0] position_deviation = 32'h0;
  logic               speed_limited_flag, approach_flag, motor_power_on, drive_ready, irq;
  logic               main_supply_ok, control_supply_ok, undervoltage_alarm;
  logic               servo_on_req = 1'b1;
  logic               cut_main = 1'b0;
  logic               cut_control = 1'b0;
  logic               heavy_load = 1'b0;
  int                 n_fail = 0;
  int                 n_tests = 0;
  int                 cyc = 0;

  always #20 clk_sys = !clk_sys;

  drive_cap_outage #(.MS_CYCLES(4)) drive_cap_outage_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_demand(speed_demand),
    .speed_cmd(speed_cmd), .speed_limited_flag(speed_limited_flag),
    .position_deviation(position_deviation), .approach_flag(approach_flag),
    .main_supply_ok(main_supply_ok), .control_supply_ok(control_supply_ok),
    .undervoltage_alarm(undervoltage_alarm), .servo_on_req(servo_on_req),
    .motor_power_on(motor_power_on), .drive_ready(drive_ready), .irq(irq));

  supply_link_model supply_link_model_inst (
    .clk_sys(clk_sys), .cut_main(cut_main), .cut_control(cut_control), .heavy_load(heavy_load),
    .main_supply_ok(main_supply_ok), .control_supply_ok(control_supply_ok),
    .undervoltage_alarm(undervoltage_alarm));

  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(drive_cap_pkg::CTRL_OFS, 32'h0);
    rd_chk(drive_cap_pkg::TORQUE_CAP_OFS, 32'h2710);
    rd_chk(drive_cap_pkg::FORCE_CAP_OFS, 32'h2710);
    rd_chk(drive_cap_pkg::RIDE_TIME_OFS, 32'h14);
    rd_chk(drive_cap_pkg::NEAR_OFS, 32'h4000_0000);
    rd_chk(drive_cap_pkg::EV_ENABLE_OFS, 32'h0);
    rd_chk(8'hfc, 32'h0);
    chk(drive_ready, 32'h1);
    // Out-of-range writes saturate
    wr(drive_cap_pkg::TORQUE_CAP_OFS, 32'h4e20);
    rd_chk(drive_cap_pkg::TORQUE_CAP_OFS, 32'h2710);
    wr(drive_cap_pkg::RIDE_TIME_OFS, 32'h5);
    rd_chk(drive_cap_pkg::RIDE_TIME_OFS, 32'h14);
    wr(drive_cap_pkg::RIDE_TIME_OFS, 32'hc351);
    rd_chk(drive_cap_pkg::RIDE_TIME_OFS, 32'hc350);
    wr(drive_cap_pkg::RIDE_TIME_OFS, 32'h14);
    // Speed mode: no clamp, demand of -1500 passes
    wr(drive_cap_pkg::TORQUE_CAP_OFS, 32'h3e8);
    speed_demand <= 17'h1fa24;
    wait_cyc(3);
    chk(32'(speed_cmd), 32'hffff_fa24);
    chk(speed_limited_flag, 32'h0);
    wr(drive_cap_pkg::CTRL_OFS, 32'h1);
    rd_chk(drive_cap_pkg::LIMIT_OFS, 32'h3e8);
    wait_cyc(2);
    chk(32'(speed_cmd), 32'hffff_fc18);
    chk(speed_limited_flag, 32'h1);
    speed_demand <= 17'h001f4;
    wait_cyc(3);
    chk(32'(speed_cmd), 32'h1f4);
    chk(speed_limited_flag, 32'h0);
    // Cap above motor maximum falls back to the source speed
    wr(drive_cap_pkg::MAX_SPEED_OFS, 32'h320);
    rd_chk(drive_cap_pkg::LIMIT_OFS, 32'h320);
    wr(drive_cap_pkg::OVERSPEED_OFS, 32'h384);
    wr(drive_cap_pkg::CTRL_OFS, 32'h5);
    rd_chk(drive_cap_pkg::LIMIT_OFS, 32'h384);
    wr(drive_cap_pkg::CTRL_OFS, 32'h3);
    rd_chk(drive_cap_pkg::LIMIT_OFS, 32'h320);
    wr(drive_cap_pkg::FORCE_CAP_OFS, 32'h2bc);
    rd_chk(drive_cap_pkg::LIMIT_OFS, 32'h2bc);
    speed_demand <= 17'h00000;
    // Near width kept above completion width
    wr(drive_cap_pkg::COMPL_OFS, 32'h5);
    rd_chk(drive_cap_pkg::COMPL_OFS, 32'h5);
    wr(drive_cap_pkg::NEAR_OFS, 32'ha);
    position_deviation <= 32'hffff_fff6;
    wait_cyc(3);
    chk(approach_flag, 32'h1);
    position_deviation <= 32'hffff_fff5;
    wait_cyc(3);
    chk(approach_flag, 32'h0);
    position_deviation <= 32'h0000_000a;
    wait_cyc(3);
    chk(approach_flag, 32'h1);
    // Outage longer than 20 ms of 4 cycles cuts power
    wr(drive_cap_pkg::EV_CLEAR_OFS, 32'hf);
    wr(drive_cap_pkg::EV_ENABLE_OFS, 32'h4);
    wait_cyc(1);
    chk(irq, 32'h0);
    cut_main <= 1'b1;
    wait_cyc(70);
    chk({motor_power_on, drive_ready}, 32'h3);
    wait_cyc(25);
    chk(motor_power_on, 32'h0);
    chk(drive_ready, 32'h0);
    chk(irq, 32'h1);
    rd_chk(drive_cap_pkg::EV_STATUS_OFS, 32'h6);
    wr(drive_cap_pkg::EV_CLEAR_OFS, 32'h4);
    wait_cyc(2);
    chk(irq, 32'h0);
    cut_main <= 1'b0;
    wait_cyc(4);
    chk({motor_power_on, drive_ready}, 32'h3);
    // Hold time restarts from zero on the next outage
    cut_main <= 1'b1;
    wait_cyc(70);
    chk(motor_power_on, 32'h1);
    heavy_load <= 1'b1;
    wait_cyc(4);
    chk(motor_power_on, 32'h0);
    chk(irq, 32'h1);
    wr(drive_cap_pkg::EV_ENABLE_OFS, 32'h0);
    wait_cyc(2);
    chk(irq, 32'h0);
    cut_main <= 1'b0;
    heavy_load <= 1'b0;
    wait_cyc(4);
    chk(motor_power_on, 32'h1);
    cut_control <= 1'b1;
    wait_cyc(4);
    chk({motor_power_on, drive_ready}, 32'h0);
    cut_control <= 1'b0;
    wait_cyc(4);
    chk({motor_power_on, drive_ready}, 32'h3);
    // Short outage inside the ride time keeps power and ready
    wr(drive_cap_pkg::EV_CLEAR_OFS, 32'hf);
    cut_main <= 1'b1;
    wait_cyc(40);
    rd_chk(drive_cap_pkg::STATUS_OFS, 32'h1e);
    cut_main <= 1'b0;
    wait_cyc(4);
    chk({motor_power_on, drive_ready}, 32'h3);
    rd_chk(drive_cap_pkg::EV_STATUS_OFS, 32'ha);
    servo_on_req <= 1'b0;
    wait_cyc(2);
    chk({motor_power_on, drive_ready}, 32'h1);
    servo_on_req <= 1'b1;
    end_of_test();
  end
endmodule : tb
